// ==== ssp_defs.vh ====
// Constants for the synchronous serial port
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define SSP_MODE_DIV4 4'h0
`define SSP_MODE_DIV16 4'h1
`define SSP_MODE_DIV64 4'h2
`define SSP_MODE_TMR 4'h3
`define SSP_MODE_SLV_SS 4'h4
`define SSP_MODE_SLV 4'h5
`define SSP_DIV4_HALF 8'h01
`define SSP_DIV16_HALF 8'h07
`define SSP_DIV64_HALF 8'h1f
`define SSP_BITS 4'h8
`endif

// ==== ssp_sync2.v ====
// Two-flop synchroniser for one level
module ssp_sync2 (
  input wire clock,
  input wire rst,
  input wire din,
  output reg dout
);
  reg meta_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ==== ssp_buf2.v ====
// Two-entry valid/ready buffer
module ssp_buf2 #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst,
  input wire flush,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg wrPtr_q;
  reg rdPtr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (flush) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// ==== ssp_sync_serial_port.v ====
// SPI mode of the synchronous serial port, master and slave roles
`include "ssp_defs.vh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Shift MSb first in both roles
// - After eight bits, load buffer, set flags
// - Received bytes are double buffered
// - Write during shift ignored, sets collision
// - Buffer read clears the full flag; code sets it again next cycle while a second byte remains
// - Shift register reached only via buffer
// - Master starts shifting on buffer write
// - Receive continues with data output disabled
// - Clock idle level follows polarity bit
// - Master rate: div 4, 16, 64, timer/2
// - Edge bit set: data valid before edge
// - Slave shifts on external clock edges
// - Slave needs the processor clock to sample SCK
// - Mode 04h: shift only while select low
// - Select high floats data output within three cycles
// - Select high or disable clears counter
// - Output pin as input stops transmitting
// - Sample bit picks middle or end in master role; slave samples on leading edge
// - SPI modes map onto polarity/edge bits
// - Reset disables port, aborts transfer
module ssp_sync_serial_port (
  input wire clock,
  input wire rst,
  input wire portEnableBit,
  input wire [3:0] portModeField,
  input wire clockPolarityBit,
  input wire clockEdgeBit,
  input wire samplePhaseBit,
  input wire sdoTrisBit,
  input wire sckTrisBit,
  input wire timerTick,
  input wire [7:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  input wire wcolClear,
  input wire sdiPin,
  input wire sckIn,
  input wire ssInN,
  output reg [7:0] readData,
  output reg bufferFullFlag,
  output reg portIrqFlag,
  output reg writeCollisionFlag,
  output reg busy,
  output reg sdoOut,
  output reg sdoOe,
  output reg sckOut,
  output reg sckOe
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LEAD = 3'b010;
  localparam ST_TRAIL = 3'b100;

  wire sdiS;
  wire sckS;
  wire ssS;
  reg sckPrev_q;
  reg [2:0] state_q;
  reg [7:0] shift_q;
  reg [3:0] bitCnt_q;
  reg [7:0] divCnt_q;
  reg tmrHalf_q;
  reg sampled_q;
  reg irqClear_q;
  wire master;
  wire slave;
  wire ssCtl;
  wire portReset;
  wire slaveOn;
  wire sckRise;
  wire sckFall;
  wire leadEdge;
  wire trailEdge;
  reg [7:0] halfPeriod;
  wire tick;
  reg doneValid;
  reg [7:0] doneData;
  wire doneReady;
  wire bufValid;
  wire [7:0] bufData;
  wire popBuf;

  ssp_sync2 uSdi (.clock(clock), .rst(rst), .din(sdiPin), .dout(sdiS));
  ssp_sync2 uSck (.clock(clock), .rst(rst), .din(sckIn), .dout(sckS));
  ssp_sync2 uSs (.clock(clock), .rst(rst), .din(ssInN), .dout(ssS));

  assign master = (portModeField <= `SSP_MODE_TMR);
  assign slave = (portModeField == `SSP_MODE_SLV_SS) ||
                 (portModeField == `SSP_MODE_SLV);
  assign ssCtl = (portModeField == `SSP_MODE_SLV_SS);
  // Select high resets only in select-controlled slave mode
  assign portReset = !portEnableBit || (ssCtl && ssS);
  assign slaveOn = portEnableBit && slave && !(ssCtl && ssS);
  assign sckRise = sckS && !sckPrev_q;
  assign sckFall = !sckS && sckPrev_q;
  // Leading edge leaves idle level; polarity inverts the sense
  assign leadEdge = clockPolarityBit ? sckFall : sckRise;
  assign trailEdge = clockPolarityBit ? sckRise : sckFall;

  //////////////////////////////////////////////////////////////////////////
  // Master bit-rate generator
  always @* begin
    case (portModeField)
      `SSP_MODE_DIV4: halfPeriod = `SSP_DIV4_HALF;
      `SSP_MODE_DIV16: halfPeriod = `SSP_DIV16_HALF;
      `SSP_MODE_DIV64: halfPeriod = `SSP_DIV64_HALF;
      default: halfPeriod = 8'h00;
    endcase
  end

  // Timer mode: each timer tick gives one half period, so rate is timer/2
  assign tick = (portModeField == `SSP_MODE_TMR) ? timerTick :
                (divCnt_q == halfPeriod);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      divCnt_q <= 8'h00;
      tmrHalf_q <= 1'b0;
    end else if (state_q == ST_IDLE || tick) begin
      divCnt_q <= 8'h00;
      tmrHalf_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
      tmrHalf_q <= tmrHalf_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Completed bytes enter the two-entry receive buffer
  ssp_buf2 #(.WIDTH(8)) uBuf (
    .clock(clock),
    .rst(rst),
    .flush(!portEnableBit),
    .inValid(doneValid),
    .inReady(doneReady),
    .inData(doneData),
    .outValid(bufValid),
    .outReady(popBuf),
    .outData(bufData)
  );

  // A read pops the shown byte; the next one then appears
  assign popBuf = readStrobe && bufValid;

  //////////////////////////////////////////////////////////////////////////
  // Shift engine
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      sampled_q <= 1'b0;
      sckPrev_q <= 1'b0;
      doneValid <= 1'b0;
      doneData <= 8'h00;
      sckOut <= 1'b0;
      sdoOut <= 1'b0;
      busy <= 1'b0;
    end else begin
      sckPrev_q <= sckS;
      // Hold a finished byte until the buffer accepts it
      if (doneValid && doneReady) begin
        doneValid <= 1'b0;
      end
      if (portReset) begin
        state_q <= ST_IDLE;
        bitCnt_q <= 4'h0;
        busy <= 1'b0;
        sckOut <= clockPolarityBit;
      end else if (master) begin
        case (state_q)
          ST_IDLE: begin
            sckOut <= clockPolarityBit;
            // Ignore a new byte while a finished byte still waits to enter the buffer
            if (writeStrobe && !busy && !doneValid) begin
              shift_q <= writeData;
              sdoOut <= writeData[7];
              bitCnt_q <= 4'h0;
              busy <= 1'b1;
              state_q <= ST_LEAD;
            end
          end
          ST_LEAD: begin
            if (tick) begin
              sckOut <= ~clockPolarityBit;
              // Edge bit clear: data changes on leading edge
              if (!clockEdgeBit && bitCnt_q != 4'h0) begin
                sdoOut <= shift_q[7];
              end
              if (!samplePhaseBit) begin
                sampled_q <= sdiS;
              end
              state_q <= ST_TRAIL;
            end
          end
          ST_TRAIL: begin
            if (tick) begin
              sckOut <= clockPolarityBit;
              shift_q <= {shift_q[6:0],
                          samplePhaseBit ? sdiS : sampled_q};
              if (clockEdgeBit) begin
                sdoOut <= shift_q[6];
              end
              if (bitCnt_q == `SSP_BITS - 4'h1) begin
                doneValid <= 1'b1;
                doneData <= {shift_q[6:0],
                             samplePhaseBit ? sdiS : sampled_q};
                busy <= 1'b0;
                bitCnt_q <= 4'h0;
                state_q <= ST_IDLE;
              end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
                state_q <= ST_LEAD;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end else if (slaveOn) begin
        state_q <= ST_IDLE;
        // Slave data may be loaded while idle between bytes
        if (writeStrobe && !busy) begin
          shift_q <= writeData;
          sdoOut <= writeData[7];
        end
        if (leadEdge) begin
          busy <= 1'b1;
          if (!clockEdgeBit && bitCnt_q != 4'h0) begin
            sdoOut <= shift_q[7];
          end
          sampled_q <= sdiS;
        end
        if (trailEdge) begin
          shift_q <= {shift_q[6:0], sampled_q};
          if (clockEdgeBit) begin
            sdoOut <= shift_q[6];
          end
          if (bitCnt_q == `SSP_BITS - 4'h1) begin
            doneValid <= 1'b1;
            doneData <= {shift_q[6:0], sampled_q};
            bitCnt_q <= 4'h0;
            busy <= 1'b0;
          end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sdoOe <= 1'b0;
      sckOe <= 1'b0;
    end else begin
      // Direction bit set stops transmission on the pin
      sdoOe <= portEnableBit && !sdoTrisBit &&
               (master || slaveOn);
      sckOe <= portEnableBit && master && !sckTrisBit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software-facing flags
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      readData <= 8'h00;
      bufferFullFlag <= 1'b0;
      portIrqFlag <= 1'b0;
      writeCollisionFlag <= 1'b0;
      irqClear_q <= 1'b0;
    end else begin
      irqClear_q <= readStrobe;
      readData <= bufValid ? bufData : readData;
      // Full tracks buffer occupancy; a new byte wins over a read
      bufferFullFlag <= bufValid && !(popBuf && !doneValid) ||
                        (doneValid && doneReady);
      if (doneValid && doneReady) begin
        portIrqFlag <= 1'b1;
      end else if (irqClear_q) begin
        portIrqFlag <= 1'b0;
      end
      if (writeStrobe && portEnableBit && busy) begin
        writeCollisionFlag <= 1'b1;
      end else if (wcolClear) begin
        writeCollisionFlag <= 1'b0;
      end
    end
  end
endmodule

// ==== ssp_checker.sv ====
// Assertions on the serial port's pins and flags
`include "ssp_defs.vh"
module ssp_checker (
  input wire clock,
  input wire rst,
  input wire portEnableBit,
  input wire [3:0] portModeField,
  input wire clockPolarityBit,
  input wire sdoTrisBit,
  input wire writeStrobe,
  input wire wcolClear,
  input wire ssInN,
  input wire bufferFullFlag,
  input wire portIrqFlag,
  input wire writeCollisionFlag,
  input wire busy,
  input wire sdoOe,
  input wire sckOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire mst = portEnableBit && portModeField < 4'h4;
  AST_WRITE_COLLISION_FLAG_SET: assert property (
    writeStrobe && busy |=> writeCollisionFlag) else $error("no collision");
  AST_WRITE_COLLISION_FLAG_HOLD: assert property (
    writeCollisionFlag && !wcolClear && portEnableBit |=> writeCollisionFlag)
    else $error("collision flag lost");
  AST_START: assert property (
    mst && writeStrobe && !busy && !bufferFullFlag |=> busy)
    else $error("write did not start");
  AST_SCK_IDLE: assert property (
    mst && !$past(rst) && $past(portEnableBit) && !busy && !$past(busy)
    |-> sckOut == clockPolarityBit) else $error("clock not idle");
  AST_SDO_OFF: assert property (
    sdoTrisBit && $past(sdoTrisBit) |-> !sdoOe) else $error("data driven");
  AST_SS_FLOAT: assert property (
    (portModeField == `SSP_MODE_SLV_SS && ssInN) [*4] |-> !sdoOe)
    else $error("data driven while deselected");
  AST_DIS: assert property (
    !portEnableBit [*2] |-> !busy && !sdoOe) else $error("active when off");
  AST_IRQ_BF: assert property (
    $rose(portIrqFlag) |-> bufferFullFlag) else $error("irq without full");
  AST_DIV16: assert property (
    $rose(busy) && portModeField == `SSP_MODE_DIV16
    |-> ##126 busy ##[1:4] !busy) else $error("byte length wrong");
  cover property ($rose(busy));
  cover property ($rose(writeCollisionFlag));
  cover property ($rose(portIrqFlag) && portModeField == `SSP_MODE_SLV_SS);
endmodule

// ==== ssp_peer.sv ====
// Far-side peer: slave in master role, frame source in slave role
module ssp_peer (
  input wire sckOut,
  input wire sdoOut,
  output logic sckIn,
  output logic ssInN,
  output logic sdiPin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxByte = 8'h00;
  initial begin
    sckIn = 1'b0;
    ssInN = 1'b1;
    sdiPin = 1'b0;
  end
  // Sample on the leading rise, change on the fall
  always @(posedge sckOut) rxByte = {rxByte[6:0], sdoOut};
  always @(negedge sckOut) begin
    txByte = {txByte[6:0], ~txByte[0]};
    sdiPin = txByte[7];
  end
  task automatic load(input logic [7:0] b);
    txByte = b;
    sdiPin = b[7];
  endtask
  // Link clock stands still outside frames
  task automatic frame(input logic [7:0] b, input int n);
    #1.3 ssInN = 1'b0;
    #64;
    for (int i = 7; i > 7 - n; i--) begin
      sdiPin = b[i];
      #32 sckIn = 1'b1;
      #32 sckIn = 1'b0;
    end
    #64 ssInN = 1'b1;
    sdiPin = ~sdiPin;
  endtask
endmodule

// ==== ssp_sync_serial_port_bench.sv ====
// Self-checking bench for the synchronous serial port
module ssp_sync_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic portEnableBit = 1'b0;
  logic [3:0] portModeField = 4'h0;
  logic clockPolarityBit = 1'b0;
  logic clockEdgeBit = 1'b1;
  logic samplePhaseBit = 1'b0;
  logic sdoTrisBit = 1'b0;
  logic sckTrisBit = 1'b0;
  logic timerTick = 1'b0;
  logic [7:0] writeData = 8'h00;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic wcolClear = 1'b0;
  wire sdiPin, sckIn, ssInN, bufferFullFlag, portIrqFlag, writeCollisionFlag;
  wire busy, sdoOut, sdoOe, sckOut, sckOe;
  wire [7:0] readData;
  int errors = 0;
  int n_tests = 0;
  int lfsr = 81273;
  int tickCnt = 0;
  int per = 0;
  time tRise = 0;
  logic [7:0] q[$];
  logic [7:0] w, t;
  ssp_sync_serial_port dut_u (.*);
  ssp_peer peer_u (.sckOut(sckOut), .sdoOut(sdoOut), .sckIn(sckIn),
    .ssInN(ssInN), .sdiPin(sdiPin));
  always #2 clock = ~clock;
  always @(negedge clock) begin
    tickCnt = (tickCnt + 1) % 3;
    timerTick <= (tickCnt == 0);
  end
  always @(posedge sckOut) begin
    per = int'(($time - tRise) / 4);
    tRise = $time;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] b);
    @(negedge clock);
    writeData = b;
    writeStrobe = 1'b1;
    @(negedge clock);
    writeStrobe = 1'b0;
  endtask
  task automatic rd(input bit c);
    logic [7:0] e;
    e = q.pop_front();
    @(negedge clock);
    if (c) chk("readData", readData, e);
    readStrobe = 1'b1;
    @(negedge clock);
    readStrobe = 1'b0;
  endtask
  // Bounded wait; flags land up to two cycles after busy drops
  task automatic idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 1000) begin
      @(negedge clock);
      i++;
    end
    if (i == 1000) begin
      errors++;
      close_out();
    end
    cyc(3);
  endtask
  task automatic xfer();
    w = rnd();
    t = rnd();
    peer_u.load(t);
    wr(w);
    idle();
    q.push_back(t);
  endtask
  task automatic cfg(input logic [3:0] m, input logic p, input logic e);
    @(negedge clock);
    portEnableBit = 1'b0;
    @(negedge clock);
    portModeField = m;
    clockPolarityBit = p;
    clockEdgeBit = e;
    portEnableBit = 1'b1;
    cyc(2);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(2);
    for (int m = 0; m < 4; m++) begin
      cfg(4'(m), 1'b0, 1'b1);
      xfer();
      chk("peerRx", peer_u.rxByte, w);
      chk("sckPeriod", 8'(per), m == 3 ? 8'h06 : 8'(4 << (2 * m)));
      chk("sckIdle", 8'(sckOut), 8'h00);
      rd(m != 0); // Synchroniser lag leaves div4 input sampling undefined
      chk("full", 8'(bufferFullFlag), 8'h00);
    end
    cfg(4'h1, 1'b0, 1'b1);
    w = rnd();
    t = rnd();
    peer_u.load(t);
    wr(w);
    wr(rnd());
    chk("write_collision_flag", 8'(writeCollisionFlag), 8'h01);
    idle();
    q.push_back(t);
    chk("peerRx", peer_u.rxByte, w);
    rd(1);
    chk("write_collision_flag", 8'(writeCollisionFlag), 8'h01);
    @(negedge clock) wcolClear = 1'b1;
    @(negedge clock) wcolClear = 1'b0;
    cyc(1);
    chk("write_collision_flag", 8'(writeCollisionFlag), 8'h00);
    xfer();
    xfer();
    chk("full", 8'(bufferFullFlag), 8'h01);
    chk("irq", 8'(portIrqFlag), 8'h01);
    rd(1);
    rd(1);
    cyc(1);
    chk("full", 8'(bufferFullFlag), 8'h00);
    sdoTrisBit = 1'b1;
    xfer();
    rd(1);
    sdoTrisBit = 1'b0;
    cfg(4'h1, 1'b1, 1'b1);
    chk("sckIdle", 8'(sckOut), 8'h01);
    xfer();
    chk("sckIdle", 8'(sckOut), 8'h01);
    rd(0);
    wr(rnd());
    cyc(10);
    rst = 1'b1;
    cyc(1);
    chk("busy", 8'(busy), 8'h00);
    rst = 1'b0;
    cyc(2);
    sckTrisBit = 1'b1;
    for (int m = 4; m < 6; m++) begin
      cfg(4'(m), 1'b0, m == 4);
      t = rnd();
      peer_u.frame(t, 8);
      q.push_back(t);
      cyc(4);
      rd(1);
    end
    cfg(4'h4, 1'b0, 1'b1);
    peer_u.frame(rnd(), 4);
    cyc(4);
    chk("sdoOe", 8'(sdoOe), 8'h00);
    chk("full", 8'(bufferFullFlag), 8'h00);
    t = rnd();
    peer_u.frame(t, 8);
    q.push_back(t);
    cyc(4);
    rd(1);
    close_out();
  end
  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule
bind ssp_sync_serial_port ssp_checker chk_u (.*);
